// File: rtl/trunk_bus_master.sv
// Bus master that drives the trunk frame front end over the duplicated address buses
`timescale 1ns/1ps
`default_nettype none
module trunk_bus_master
  import trunk_bus_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    ce,
  input  wire logic                    cmd_valid,
  input  wire logic [2:0]              cmd_target,
  input  wire logic                    cmd_bus,
  input  wire logic [5:0]              cmd_row,
  input  wire logic                    cmd_maint,
  input  wire logic [RELAY_BITS-1:0]   cmd_relay_addr,
  input  wire logic [ENABLE_PAIRS-1:0] confirm_bus0,
  input  wire logic [ENABLE_PAIRS-1:0] confirm_bus1,
  input  wire logic [SENSORS-1:0]      scan_result_bus,
  input  wire logic                    single_row_ok_pulse,
  output logic                         ready_ff,
  output logic                         done_ff,
  output logic                         confirm_ok_ff,
  output logic                         row_ok_ff,
  output logic [SENSORS-1:0]           result_ff,
  output logic [ENABLE_PAIRS-1:0]      bus0_enable_ff,
  output logic [ENABLE_PAIRS-1:0]      bus1_enable_ff,
  output logic [ADDR_BITS-1:0]         bus0_addr_ff,
  output logic [ADDR_BITS-1:0]         bus1_addr_ff
);
  state_type                state_ff, nxt_state;
  logic [8:0]               tmr_ff, nxt_tmr;
  logic [2:0]               tgt_ff, nxt_tgt;
  logic                     bus_ff, nxt_bus;
  logic [ADDR_BITS-1:0]     word_ff, nxt_word;
  logic                     nxt_ready, nxt_done, nxt_confirm_ok, nxt_row_ok;
  logic [SENSORS-1:0]       nxt_result;
  logic [ENABLE_PAIRS-1:0]  nxt_en0, nxt_en1;
  logic [ADDR_BITS-1:0]     nxt_ad0, nxt_ad1;
  logic                     take;
  logic                     is_scan;
  logic                     confirm_hit;

  assign take = cmd_valid && ready_ff && (cmd_target <= TGT_LAST);
  assign is_scan = (tgt_ff == TGT_SCAN0) || (tgt_ff == TGT_SCAN1);
  // Echo is taken only from the pair that was enabled, on the bus in use
  assign confirm_hit = bus_ff ? confirm_bus1[tgt_ff] : confirm_bus0[tgt_ff];

  // Address word: scanner gets one pair per group or the test pair alone
  function automatic logic [ADDR_BITS-1:0] build_word(input logic [2:0] tgt,
                                                      input logic [5:0] row,
                                                      input logic maint,
                                                      input logic [RELAY_BITS-1:0] raddr);
    logic [ADDR_BITS-1:0] w;
    w = '0;
    if (tgt == TGT_SCAN0 || tgt == TGT_SCAN1) begin
      if (maint) begin
        w[MAINT_POS] = 1'b1;
      end else begin
        w[LOW_POS + 32'(row[2:0])]  = 1'b1;
        w[HIGH_POS + 32'(row[5:3])] = 1'b1;
      end
    end else begin
      // Operate or release is part of this word; the front end decodes it
      w[RELAY_BITS-1:0] = raddr;
    end
    return w;
  endfunction : build_word

  always_comb begin
    nxt_state      = state_ff;
    nxt_tmr        = tmr_ff;
    nxt_tgt        = tgt_ff;
    nxt_bus        = bus_ff;
    nxt_word       = word_ff;
    nxt_done       = 1'b0;
    nxt_confirm_ok = confirm_ok_ff;
    nxt_row_ok     = row_ok_ff;
    nxt_result     = result_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_tmr = '0;
        if (take) begin
          nxt_state      = ST_ENABLE;
          nxt_tgt        = cmd_target;
          nxt_bus        = cmd_bus;
          nxt_word       = build_word(cmd_target, cmd_row, cmd_maint, cmd_relay_addr);
          nxt_confirm_ok = 1'b0;
          nxt_row_ok     = 1'b0;
          nxt_result     = '0;
        end
      end
      ST_ENABLE: begin
        nxt_tmr = tmr_ff + 9'h001;
        if (tmr_ff == 9'(PULSE_CYC - 1)) nxt_state = ST_ADDR;
      end
      ST_ADDR: begin
        nxt_tmr = tmr_ff + 9'h001;
        if (tmr_ff == 9'(2 * PULSE_CYC - 1)) nxt_state = ST_LISTEN;
      end
      ST_LISTEN: begin
        nxt_tmr = tmr_ff + 9'h001;
        if (confirm_hit) nxt_confirm_ok = 1'b1;
        // A set bit means no loop current on that sensor
        if (is_scan) nxt_result = result_ff | scan_result_bus;
        if (is_scan && single_row_ok_pulse) nxt_row_ok = 1'b1;
        if (tmr_ff == 9'(LISTEN_CYC - 1)) nxt_state = ST_SPACE;
      end
      ST_SPACE: begin
        nxt_tmr = tmr_ff + 9'h001;
        // Spacing counts from address start so back to back scans stay legal
        if (tmr_ff == 9'(PULSE_CYC + SPACE_CYC - 1)) begin
          nxt_state = ST_IDLE;
          nxt_done  = 1'b1;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_tmr   = '0;
      end
    endcase
    nxt_ready = (nxt_state == ST_IDLE);
    nxt_en0 = '0;
    nxt_en1 = '0;
    nxt_ad0 = '0;
    nxt_ad1 = '0;
    if (nxt_state == ST_ENABLE) begin
      if (nxt_bus) nxt_en1[nxt_tgt] = 1'b1;
      else         nxt_en0[nxt_tgt] = 1'b1;
    end
    if (nxt_state == ST_ADDR) begin
      if (nxt_bus) nxt_ad1 = nxt_word;
      else         nxt_ad0 = nxt_word;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff       <= ST_IDLE;
      tmr_ff         <= '0;
      tgt_ff         <= '0;
      bus_ff         <= 1'b0;
      word_ff        <= '0;
      ready_ff       <= 1'b0;
      done_ff        <= 1'b0;
      confirm_ok_ff  <= 1'b0;
      row_ok_ff      <= 1'b0;
      result_ff      <= '0;
      bus0_enable_ff <= '0;
      bus1_enable_ff <= '0;
      bus0_addr_ff   <= '0;
      bus1_addr_ff   <= '0;
    end else if (ce) begin
      state_ff       <= nxt_state;
      tmr_ff         <= nxt_tmr;
      tgt_ff         <= nxt_tgt;
      bus_ff         <= nxt_bus;
      word_ff        <= nxt_word;
      ready_ff       <= nxt_ready;
      done_ff        <= nxt_done;
      confirm_ok_ff  <= nxt_confirm_ok;
      row_ok_ff      <= nxt_row_ok;
      result_ff      <= nxt_result;
      bus0_enable_ff <= nxt_en0;
      bus1_enable_ff <= nxt_en1;
      bus0_addr_ff   <= nxt_ad0;
      bus1_addr_ff   <= nxt_ad1;
    end
  end

  // Helper logic for the checks below
  logic       en_any, ad_any, ad_rise;
  logic       ad_prev_ff;
  logic [9:0] since_ad_ff;
  logic [ADDR_BITS-1:0] ad_all;
  assign en_any  = |{bus0_enable_ff, bus1_enable_ff};
  assign ad_all  = bus0_addr_ff | bus1_addr_ff;
  assign ad_any  = |ad_all;
  assign ad_rise = ad_any && !ad_prev_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      ad_prev_ff  <= 1'b0;
      since_ad_ff <= 10'h3ff;
    end else if (ce) begin
      ad_prev_ff  <= ad_any;
      since_ad_ff <= ad_rise ? 10'h000 : (since_ad_ff == 10'h3ff ? since_ad_ff
                                                                  : since_ad_ff + 10'h001);
    end
  end

  property p_addr_spacing;
    @(posedge clk) disable iff (reset) ad_rise |-> since_ad_ff >= 10'(SPACE_CYC - 1);
  endproperty
  a_addr_spacing: assert property (p_addr_spacing) else $error("address repeat too soon");

  property p_one_path;
    @(posedge clk) disable iff (reset) $onehot0({bus0_enable_ff, bus1_enable_ff});
  endproperty
  a_one_path: assert property (p_one_path) else $error("more than one enable pair");

  property p_addr_after_enable;
    @(posedge clk) disable iff (reset || !ce) $rose(en_any) |-> ##25 (!en_any && ad_any);
  endproperty
  a_addr_after_enable: assert property (p_addr_after_enable)
    else $error("address not after enable");

  property p_one_bus;
    @(posedge clk) disable iff (reset) !(|bus0_addr_ff && |bus1_addr_ff);
  endproperty
  a_one_bus: assert property (p_one_bus) else $error("address on both buses");

  property p_groups;
    @(posedge clk) disable iff (reset) (ad_any && is_scan && !ad_all[MAINT_POS]) |->
      ($onehot(ad_all[HIGH_POS-1:LOW_POS]) && $onehot(ad_all[MAINT_POS-1:HIGH_POS]));
  endproperty
  a_groups: assert property (p_groups) else $error("scan group not one pair each");

  property p_maint_alone;
    @(posedge clk) disable iff (reset) (is_scan && ad_all[MAINT_POS]) |->
      ad_all[MAINT_POS-1:0] == '0;
  endproperty
  a_maint_alone: assert property (p_maint_alone) else $error("test pair not alone");

  c_scan:  cover property (@(posedge clk) disable iff (reset) done_ff && is_scan && row_ok_ff);
  c_relay: cover property (@(posedge clk) disable iff (reset)
                           done_ff && !is_scan && confirm_ok_ff);
  c_bus1:  cover property (@(posedge clk) disable iff (reset) $rose(|bus1_enable_ff));
endmodule : trunk_bus_master
`default_nettype wire

// File: rtl/trunk_bus_pkg.sv
// Constants for the trunk frame bus master
//
// Overview of operation
// - Master picks one bus and controller, confirms it on the activation confirm lead.
// - Address leads named by bus 0 or 1, bit 00 to 36, polarity.
// - Scanner address is a low order group and a high order group, eight pairs each.
// - One extra pair carries maintenance test orders, apart from both groups.
// - Master must not address the scanner again within 7 us.
package trunk_bus_pkg;
  localparam int CLK_NS        = 20;
  localparam int PULSE_NS      = 500;
  localparam int LISTEN_NS     = 3000;
  localparam int MIN_SPACE_NS  = 7000;
  // Cycle counts; least times round up
  localparam int PULSE_CYC     = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int LISTEN_CYC    = (LISTEN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SPACE_CYC     = (MIN_SPACE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADDR_BITS     = 37;
  localparam int RELAY_BITS    = 28;
  localparam int ENABLE_PAIRS  = 6;
  localparam int SENSORS       = 16;
  localparam int GROUP_PAIRS   = 8;
  localparam int LOW_POS       = 0;
  localparam int HIGH_POS      = 8;
  localparam int MAINT_POS     = 16;
  localparam logic [2:0] TGT_SCAN0  = 3'h0;
  localparam logic [2:0] TGT_SCAN1  = 3'h1;
  localparam logic [2:0] TGT_LAST   = 3'h5;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ENABLE = 3'h1,
    ST_ADDR   = 3'h3,
    ST_LISTEN = 3'h2,
    ST_SPACE  = 3'h6
  } state_type;
endpackage : trunk_bus_pkg

// File: tb/front_end_model.sv
// Behavioural front end that answers the bus master like the frame would
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        drop_confirm,
  input  wire logic [5:0]  en0,
  input  wire logic [5:0]  en1,
  input  wire logic [36:0] addr0,
  input  wire logic [36:0] addr1,
  output logic      [5:0]  confirm0_ff,
  output logic      [5:0]  confirm1_ff,
  output logic      [15:0] result_ff,
  output logic             row_ok_ff
);
  logic [7:0]  tmr_ff;
  logic [5:0]  pair_ff;
  logic        bus1_ff;
  logic [16:0] word_ff;
  logic [5:0]  row;
  logic        one_row;
  // Anything but one pair per group, or the test pair, means no single row was driven
  assign one_row = $countones(word_ff[7:0]) == 1 && $countones(word_ff[15:8]) == 1
                   && !word_ff[16];
  always_comb begin
    row = 6'h0;
    for (int i = 0; i < 8; i++) begin
      if (word_ff[i]) row[2:0] = i[2:0];
      if (word_ff[8+i]) row[5:3] = i[2:0];
    end
  end
  always_ff @(posedge clk) begin
    // End of cycle stands in for the armature-triggered register clear
    if (reset || tmr_ff == 8'h96) begin
      tmr_ff      <= 8'h0;
      confirm0_ff <= 6'h0;
      confirm1_ff <= 6'h0;
      result_ff   <= 16'h0;
      row_ok_ff   <= 1'b0;
    end else if (tmr_ff == 8'h0) begin
      if (|{en0, en1}) begin
        tmr_ff  <= 8'h1;
        pair_ff <= en0 | en1;
        bus1_ff <= |en1;
        word_ff <= 17'h0;
      end
    end else begin
      tmr_ff <= tmr_ff + 8'h1;
      if (tmr_ff <= 8'h6e) word_ff <= word_ff | (bus1_ff ? addr1[16:0] : addr0[16:0]);
      if (tmr_ff == 8'h64) begin
        confirm0_ff <= (drop_confirm || bus1_ff) ? 6'h0 : pair_ff;
        confirm1_ff <= (drop_confirm || !bus1_ff) ? 6'h0 : pair_ff;
        if (|pair_ff[1:0]) begin
          result_ff <= word_ff[16] ? 16'hffff
                     : one_row ? ~{row, row[3:0], row} : 16'h0;
          row_ok_ff <= one_row;
        end
      end
    end
  end
endmodule : front_end_model
`default_nettype wire

// File: tb/trunk_frame_bus_address_front_end_tb.sv
// Self-checking bench for the trunk bus master against the front end model
`timescale 1ns/1ps
`default_nettype none
module trunk_frame_bus_address_front_end_tb;
  import trunk_bus_pkg::*;
  logic                  clk       = 1'b0;
  logic                  reset     = 1'b1;
  logic                  ce        = 1'b1;
  logic                  cmd_valid = 1'b0;
  logic [2:0]            tgt       = 3'h0;
  logic                  bus       = 1'b0;
  logic [5:0]            row       = 6'h0;
  logic                  maint     = 1'b0;
  logic [RELAY_BITS-1:0] raddr     = 28'h0;
  logic                  drop      = 1'b0;
  logic [5:0]            conf0, conf1, en0, en1;
  logic [15:0]           scan, result;
  logic [36:0]           addr0, addr1;
  logic                  row_pulse, ready, done, conf_ok, row_ok;
  int                    err_total = 0;
  int                    n_checks  = 0;
  int                    cycles    = 0;

  always #10 clk = ~clk;

  trunk_bus_master u_trunk_bus_master (
    .clk(clk), .reset(reset), .ce(ce), .cmd_valid(cmd_valid), .cmd_target(tgt),
    .cmd_bus(bus), .cmd_row(row), .cmd_maint(maint), .cmd_relay_addr(raddr),
    .confirm_bus0(conf0), .confirm_bus1(conf1), .scan_result_bus(scan),
    .single_row_ok_pulse(row_pulse), .ready_ff(ready), .done_ff(done),
    .confirm_ok_ff(conf_ok), .row_ok_ff(row_ok), .result_ff(result),
    .bus0_enable_ff(en0), .bus1_enable_ff(en1), .bus0_addr_ff(addr0), .bus1_addr_ff(addr1));
  front_end_model u_front_end_model (
    .clk(clk), .reset(reset), .drop_confirm(drop), .en0(en0), .en1(en1), .addr0(addr0),
    .addr1(addr1), .confirm0_ff(conf0), .confirm1_ff(conf1), .result_ff(scan),
    .row_ok_ff(row_pulse));

  // Seven transfers of about 376 cycles each
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check_bit(string name, logic exp, logic got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit

  task automatic check_word(string name, logic [36:0] exp, logic [36:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word

  task automatic transfer(logic [2:0] t, logic b, logic [5:0] r, logic m, logic [27:0] a,
                          logic [36:0] exp_word);
    logic [36:0] word;
    logic [36:0] other;
    logic [5:0]  ens;
    int          n;
    int          en_cyc;
    int          ad_cyc;
    word = 37'h0;
    en_cyc = 0;
    ad_cyc = 0;
    other = 37'h0;
    ens = 6'h0;
    n = 0;
    while (ready !== 1'b1 && n < 5) begin
      @(negedge clk);
      n++;
    end
    tgt = t;
    bus = b;
    row = r;
    maint = m;
    raddr = a;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 600) begin
      word = word | (b ? addr1 : addr0);
      other = other | (b ? addr0 : addr1);
      ens = ens | (b ? en1 : en0);
      if (|(b ? en1 : en0)) en_cyc++;
      if (|(b ? addr1 : addr0)) ad_cyc++;
      @(negedge clk);
      n++;
    end
    check_bit("done", 1'b1, done);
    check_word("enable pair", 37'h1 << t, {31'h0, ens});
    check_word("address word", exp_word, word);
    check_word("idle bus", 37'h0, other);
    check_word("enable width", 37'(PULSE_CYC), 37'(en_cyc));
    check_word("address width", 37'(PULSE_CYC), 37'(ad_cyc));
  endtask : transfer

  task automatic outcome(logic ok, logic rok, logic [15:0] res);
    check_bit("confirm ok", ok, conf_ok);
    check_bit("row ok", rok, row_ok);
    check_word("result", {21'h0, res}, {21'h0, result});
  endtask : outcome

  task automatic test_reset();
    @(negedge clk);
    check_bit("ready in reset", 1'b0, ready);
    check_bit("done in reset", 1'b0, done);
    @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    check_bit("ready after reset", 1'b1, ready);
    $display("test_reset ended");
  endtask : test_reset

  task automatic test_scans();
    transfer(TGT_SCAN0, 1'b0, 6'h3a, 1'b0, 28'h0, 37'h8004);
    outcome(1'b1, 1'b1, 16'h1545);
    // Back to back on the other bus and controller
    transfer(TGT_SCAN1, 1'b1, 6'h05, 1'b0, 28'h0, 37'h120);
    outcome(1'b1, 1'b1, 16'heaba);
    $display("test_scans ended");
  endtask : test_scans

  task automatic test_maint();
    transfer(TGT_SCAN0, 1'b1, 6'h00, 1'b1, 28'h0, 37'h10000);
    outcome(1'b1, 1'b0, 16'hffff);
    $display("test_maint ended");
  endtask : test_maint

  task automatic test_relay();
    transfer(TGT_LAST, 1'b0, 6'h00, 1'b0, 28'hb6d3a5c, 37'hb6d3a5c);
    outcome(1'b1, 1'b0, 16'h0);
    // Relay halves 3 and 4 are reached on their own enable pairs; 2 is left to test_lost_confirm
    transfer(3'h3, 1'b0, 6'h00, 1'b0, 28'h4924924, 37'h4924924);
    outcome(1'b1, 1'b0, 16'h0);
    transfer(3'h4, 1'b1, 6'h00, 1'b0, 28'h8000001, 37'h8000001);
    outcome(1'b1, 1'b0, 16'h0);
    $display("test_relay ended");
  endtask : test_relay

  task automatic test_lost_confirm();
    drop = 1'b1;
    transfer(3'h2, 1'b1, 6'h00, 1'b0, 28'h0000001, 37'h1);
    outcome(1'b0, 1'b0, 16'h0);
    drop = 1'b0;
    $display("test_lost_confirm ended");
  endtask : test_lost_confirm

  task automatic test_refused();
    logic [5:0] ens;
    ens = 6'h0;
    tgt = 3'h6;
    cmd_valid = 1'b1;
    repeat (30) begin
      @(negedge clk);
      ens = ens | en0 | en1;
    end
    cmd_valid = 1'b0;
    check_bit("ready held", 1'b1, ready);
    check_word("no enable", 37'h0, {31'h0, ens});
    $display("test_refused ended");
  endtask : test_refused

  task automatic test_freeze();
    logic [5:0] ens;
    ens = 6'h0;
    ce = 1'b0;
    tgt = TGT_SCAN0;
    cmd_valid = 1'b1;
    repeat (10) begin
      @(negedge clk);
      ens = ens | en0 | en1;
    end
    ce = 1'b1;
    cmd_valid = 1'b0;
    check_bit("ready frozen", 1'b1, ready);
    check_word("no enable frozen", 37'h0, {31'h0, ens});
    $display("test_freeze ended");
  endtask : test_freeze

  initial begin
    test_reset();
    test_scans();
    test_maint();
    test_relay();
    test_lost_confirm();
    test_refused();
    test_freeze();
    give_verdict();
  end
endmodule : trunk_frame_bus_address_front_end_tb
`default_nettype wire
